// file: core/spm_map.svh
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH
// Register byte offsets on the APB
`define SPM_CTRL_OFS 8'h00
`define SPM_RATE_OFS 8'h04
`define SPM_TXDATA_OFS 8'h08
`define SPM_RXDATA_OFS 8'h0C
`define SPM_PINS_OFS 8'h10
`define SPM_STATUS_OFS 8'h14
`define SPM_NOTIFY_OFS 8'h18
`define SPM_NPORT_OFS 8'h1C
// Control register field positions
`define SPM_CTRL_PROG 0
`define SPM_CTRL_DHCP 1
`define SPM_CTRL_RM_LO 2
`define SPM_CTRL_CM_LO 4
`define SPM_CTRL_HS 6
`define SPM_CTRL_IF_LO 7
`define SPM_CTRL_TRM 9
`define SPM_CTRL_SE 10
`define SPM_CTRL_LEN8 11
`define SPM_CTRL_PAR_LO 12
`define SPM_CTRL_INV 15
`define SPM_CTRL_NB_LO 16
// Reset values: routing mode, 8 bits, no parity, board-level sense
`define SPM_CTRL_RST 22'h00_0800
`define SPM_NPORT_RST 16'h0000
// Timing: clock rate and line rates in bits per second
`define SPM_CLK_HZ 40000000
`define SPM_MAX_BPS 115200
`define SPM_DFLT_BPS 9600
// Shortest bit period rounds up, so the top rate is never exceeded
`define SPM_MIN_DIV ((`SPM_CLK_HZ + `SPM_MAX_BPS - 1) / `SPM_MAX_BPS)
`define SPM_DFLT_DIV (`SPM_CLK_HZ / `SPM_DFLT_BPS)
// Character that counts as an escape while the port is closed
`define SPM_ESC_CHAR 8'h1B
`endif

// file: core/spm_pkg.sv
package spm_pkg;
  typedef enum logic [1:0] {
    SPM_RM_SERVER = 2'b00,
    SPM_RM_SRVCLI = 2'b01,
    SPM_RM_CLIENT = 2'b10
  } spm_route_t;
  typedef enum logic [2:0] {
    SPM_PAR_NONE = 3'b000,
    SPM_PAR_EVEN = 3'b001,
    SPM_PAR_ODD = 3'b010,
    SPM_PAR_MARK = 3'b011,
    SPM_PAR_SPACE = 3'b100
  } spm_parity_t;
  typedef enum logic [1:0] {
    SPM_TX_IDLE = 2'b00,
    SPM_TX_SHIFT = 2'b01
  } spm_tx_state_t;
  typedef enum logic [1:0] {
    SPM_RX_IDLE = 2'b00,
    SPM_RX_START = 2'b01,
    SPM_RX_DATA = 2'b10,
    SPM_RX_STOP = 2'b11
  } spm_rx_state_t;
endpackage

// file: core/spm_route_buf.sv
`timescale 1ns/100ps
`default_nettype none
module spm_route_buf #(
  parameter int W = 9,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Async reset, high
  input wire logic flush_i, // Discard all content
  input wire logic in_valid_i, // Write request
  input wire logic [W-1:0] in_data_i, // Write data
  output logic in_ready_o, // Room for a word
  output logic out_valid_o, // Word available
  output logic [W-1:0] out_data_o, // Oldest word
  input wire logic out_ready_i, // Consumer takes word
  output logic [AW:0] level_o // Words held
);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come from the true count, never guessed
  assign in_ready_o = cnt_q != (AW+1)'(D);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rd_q];
  assign level_o = cnt_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage is not reset; only the pointers define content
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Flush wins over traffic in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: core/spm_serial_port.sv
// Overview of operation
// RULE1: After reset the port runs in data routing mode.
// RULE2: Programming mode treats serial input as commands and drops network data.
// RULE3: Closed port ignores serial input except escapes, only with soft entry on.
// RULE4: Programming mode keeps the port always open.
// RULE5: Routing with dynamic addressing keeps the port closed until address obtained.
// RULE6: Server routing opens the port exactly while a connection exists.
// RULE7: Client routings with trigger immediate or on-data keep the port open.
// RULE8: Client routings with command triggers open only while connected.
// RULE9: Network payload leaves the serial line byte by byte, unfiltered.
// RULE10: Two independent buffers, one per routing direction.
// RULE11: Connection close flushes both routing buffers.
// RULE12: Line rate selectable up to 115200 bps, changes apply at once.
// RULE13: Character length is seven or eight data bits.
// RULE14: Mark parity produces a bit acting as second stop bit.
// RULE15: Full duplex with handshake uses RTS and CTS for flow control.
// RULE16: Half duplex drives RTS as transmit direction control.
// RULE17: Automatic interface selection takes duplex mode from the CTS level.
// RULE18: Terminal-ready mode makes DTR show connection status.
// RULE19: Connection trigger setting lets DSR start and end the connection.
// RULE20: Network host sets RTS and DTR and polls CTS and DSR.
// RULE21: Masked line changes raise a notification toward the notify port.
// RULE22: Bare modules invert handshake and data line sense.
// RULE23: In half duplex the attached device waits while direction says we drive.
`timescale 1ns/100ps
`default_nettype none
`include "spm_map.svh"
module spm_serial_port
  import spm_pkg::*;
(
  input wire logic ref_clk_i, // 40 MHz clock
  input wire logic sys_rst_i, // Async reset, high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error, unmapped address
  input wire logic ip_obtained_i, // Address acquired by network stack
  input wire logic conn_up_i, // Data connection established
  output logic conn_request_o, // Ask stack to hold the connection
  output logic notify_req_o, // Notification message pending
  output logic [15:0] notify_port_o, // Notification destination port
  input wire logic ser_rxd_i, // Serial receive pin
  input wire logic ser_cts_i, // CTS pin
  input wire logic ser_dsr_i, // DSR pin
  input wire logic aux_line_zero_i, // Auxiliary line 0 pin
  input wire logic aux_line_one_i, // Auxiliary line 1 pin
  output logic ser_txd_o, // Serial transmit pin
  output logic ser_rts_o, // RTS or direction pin
  output logic ser_dtr_o // DTR pin
);
  logic [21:0] ctrl_q;
  logic [15:0] div_q;
  logic [15:0] nport_q;
  logic rts_set_q;
  logic dtr_set_q;
  logic [5:0] note_q;
  logic [5:0] lines_q;
  logic esc_q;
  logic conn_q;
  logic [4:0] s1_q, s2_q, s3_q, filt_q;
  logic inv, prog, hs_en, half, port_open, cts_ok;
  logic [1:0] rm, cm;
  logic [2:0] par;
  logic len8;
  logic rxd, cts, dsr, aux0, aux1;
  logic wr_acc, rd_acc, ack;
  logic conn_fall;
  logic [31:0] rd_d;
  logic map_d;

  // Field decode of the control word
  assign prog = ctrl_q[`SPM_CTRL_PROG];
  assign rm = ctrl_q[`SPM_CTRL_RM_LO +: 2];
  assign cm = ctrl_q[`SPM_CTRL_CM_LO +: 2];
  assign hs_en = ctrl_q[`SPM_CTRL_HS];
  assign len8 = ctrl_q[`SPM_CTRL_LEN8]; // RULE13
  assign par = ctrl_q[`SPM_CTRL_PAR_LO +: 3];
  assign inv = ctrl_q[`SPM_CTRL_INV];

  // Pin inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_q <= 5'h1F;
      s2_q <= 5'h1F;
      s3_q <= 5'h1F;
      filt_q <= 5'h1F;
    end else begin
      s1_q <= {aux_line_one_i, aux_line_zero_i, ser_dsr_i, ser_cts_i, ser_rxd_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
    end
  end

  // Line sense flips on bare modules
  assign {aux1, aux0, dsr, cts, rxd} = filt_q ^ {2'b00, {3{inv}}}; // RULE22

  // Duplex: auto mode follows CTS; CTS low then selects full duplex and still holds transmit when handshake is on
  assign half = (ctrl_q[`SPM_CTRL_IF_LO +: 2] == 2'b10) ? cts
              : ctrl_q[`SPM_CTRL_IF_LO]; // RULE17
  assign cts_ok = half || !hs_en || cts; // RULE15

  // Opened or closed state of the port
  always_comb begin
    if (prog) begin
      port_open = 1'b1; // RULE4
    end else if (ctrl_q[`SPM_CTRL_DHCP] && !ip_obtained_i) begin
      port_open = 1'b0; // RULE5
    end else if (rm == SPM_RM_SERVER) begin
      port_open = conn_up_i; // RULE6
    end else if (cm < 2'd2) begin
      port_open = 1'b1; // RULE7
    end else begin
      port_open = conn_up_i; // RULE8
    end
  end

  // Connection close seen as a falling edge of the status input
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conn_q <= 1'b0;
    end else begin
      conn_q <= conn_up_i;
    end
  end
  assign conn_fall = conn_q && !conn_up_i;

  // APB: one wait state so read data and ready both leave flip-flops
  assign ack = psel_i && penable_i && pready_o;
  assign wr_acc = ack && pwrite_i;
  assign rd_acc = ack && !pwrite_i;

  // Routing buffers, one per direction
  logic n2s_ready, n2s_valid, n2s_pop;
  logic [7:0] n2s_data;
  logic [3:0] n2s_lvl;
  logic s2n_push, s2n_ready, s2n_valid;
  logic [8:0] s2n_in, s2n_data;
  logic [3:0] s2n_lvl;
  logic n2s_push;

  // Network data written in programming mode is dropped
  assign n2s_push = wr_acc && (paddr_i == `SPM_TXDATA_OFS) && !prog; // RULE2

  spm_route_buf #(.W(8), .D(8), .AW(3)) u_n2s_buf ( // RULE10
    .clk_i(ref_clk_i),
    .rst_i(sys_rst_i),
    .flush_i(conn_fall), // RULE11
    .in_valid_i(n2s_push),
    .in_data_i(pwdata_i[7:0]),
    .in_ready_o(n2s_ready),
    .out_valid_o(n2s_valid),
    .out_data_o(n2s_data),
    .out_ready_i(n2s_pop),
    .level_o(n2s_lvl)
  );

  spm_route_buf #(.W(9), .D(8), .AW(3)) u_s2n_buf ( // RULE10
    .clk_i(ref_clk_i),
    .rst_i(sys_rst_i),
    .flush_i(conn_fall), // RULE11
    .in_valid_i(s2n_push),
    .in_data_i(s2n_in),
    .in_ready_o(s2n_ready),
    .out_valid_o(s2n_valid),
    .out_data_o(s2n_data),
    .out_ready_i(rd_acc && (paddr_i == `SPM_RXDATA_OFS)),
    .level_o(s2n_lvl)
  );

  // Transmitter: start, 7 or 8 data bits, optional parity, stop
  spm_tx_state_t tx_st_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [15:0] tx_cnt_q;
  logic tx_line_q;
  logic [10:0] frame;
  logic pbit;

  // Mark parity is a constant one, so it reads as a second stop bit
  always_comb begin
    case (spm_parity_t'(par))
      SPM_PAR_EVEN: pbit = ^(n2s_data & {len8, 7'h7F});
      SPM_PAR_ODD: pbit = ~^(n2s_data & {len8, 7'h7F});
      SPM_PAR_MARK: pbit = 1'b1; // RULE14
      default: pbit = 1'b0;
    endcase
    frame = 11'h7FF;
    frame[0] = 1'b0;
    frame[7:1] = n2s_data[6:0];
    if (len8) begin
      frame[8] = n2s_data[7];
      frame[9] = (par != 3'b000) ? pbit : 1'b1;
    end else begin
      frame[8] = (par != 3'b000) ? pbit : 1'b1;
    end
  end

  // Bytes leave one at a time with no inspection
  assign n2s_pop = (tx_st_q == SPM_TX_IDLE) && cts_ok; // RULE9

  // Bit timing reads the divider live, so a new rate applies at once
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_st_q <= SPM_TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_bits_q <= 4'h0;
      tx_cnt_q <= 16'h0000;
      tx_line_q <= 1'b1;
    end else begin
      case (tx_st_q)
        SPM_TX_IDLE: begin
          tx_line_q <= 1'b1;
          if (n2s_valid && n2s_pop) begin // RULE15
            tx_sh_q <= frame;
            tx_bits_q <= 4'd9 + 4'(len8) + 4'(par != 3'b000);
            tx_cnt_q <= 16'h0000;
            tx_st_q <= SPM_TX_SHIFT;
          end
        end
        SPM_TX_SHIFT: begin
          if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end else if (tx_bits_q == 4'h0) begin
            tx_st_q <= SPM_TX_IDLE;
          end else begin
            tx_line_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
            tx_cnt_q <= div_q - 16'h0001; // RULE12
          end
        end
        default: tx_st_q <= SPM_TX_IDLE;
      endcase
    end
  end

  // Receiver: mid-bit sampling from the start edge
  spm_rx_state_t rx_st_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_bits_q;
  logic [15:0] rx_cnt_q;
  logic rx_done_q;
  logic [7:0] rx_byte;
  logic [3:0] rx_n;

  assign rx_n = 4'd7 + 4'(len8) + 4'(par != 3'b000);
  assign rx_byte = 8'((rx_sh_q >> (4'd9 - rx_n)) & {1'b0, len8, 7'h7F}); // RULE13

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_st_q <= SPM_RX_IDLE;
      rx_sh_q <= 9'h000;
      rx_bits_q <= 4'h0;
      rx_cnt_q <= 16'h0000;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (rx_st_q != SPM_RX_IDLE && rx_cnt_q != 16'h0000) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        case (rx_st_q)
          SPM_RX_IDLE: begin
            if (!rxd) begin
              rx_cnt_q <= {1'b0, div_q[15:1]};
              rx_st_q <= SPM_RX_START;
            end
          end
          SPM_RX_START: begin
            rx_cnt_q <= div_q - 16'h0001;
            rx_bits_q <= rx_n;
            rx_st_q <= rxd ? SPM_RX_IDLE : SPM_RX_DATA;
          end
          SPM_RX_DATA: begin
            rx_sh_q <= {rxd, rx_sh_q[8:1]};
            rx_bits_q <= rx_bits_q - 4'h1;
            rx_cnt_q <= div_q - 16'h0001;
            if (rx_bits_q == 4'h1) begin
              rx_st_q <= SPM_RX_STOP;
            end
          end
          SPM_RX_STOP: begin
            rx_done_q <= 1'b1;
            rx_st_q <= SPM_RX_IDLE;
          end
          default: rx_st_q <= SPM_RX_IDLE;
        endcase
      end
    end
  end

  // Open port records bytes; bit 8 marks a programming command
  assign s2n_push = rx_done_q && port_open; // RULE3
  assign s2n_in = {prog, rx_byte}; // RULE2

  // Escape detection only while closed and soft entry is on; set beats clear
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      esc_q <= 1'b0;
    end else if (rx_done_q && !port_open && ctrl_q[`SPM_CTRL_SE]
                 && rx_byte == `SPM_ESC_CHAR) begin
      esc_q <= 1'b1; // RULE3
    end else if (wr_acc && paddr_i == `SPM_STATUS_OFS && pwdata_i[6]) begin
      esc_q <= 1'b0;
    end
  end

  // Configuration, rate and host pin-set writes
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `SPM_CTRL_RST; // RULE1
      div_q <= 16'(`SPM_DFLT_DIV);
      nport_q <= `SPM_NPORT_RST;
      rts_set_q <= 1'b0;
      dtr_set_q <= 1'b0;
    end else if (wr_acc) begin
      case (paddr_i)
        `SPM_CTRL_OFS: ctrl_q <= pwdata_i[21:0];
        `SPM_RATE_OFS: div_q <= (pwdata_i[15:0] < 16'(`SPM_MIN_DIV))
                                ? 16'(`SPM_MIN_DIV) : pwdata_i[15:0]; // RULE12
        `SPM_PINS_OFS: {dtr_set_q, rts_set_q} <= pwdata_i[1:0]; // RULE20
        `SPM_NPORT_OFS: nport_q <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // Handshake and direction outputs, registered with the line sense applied
  logic rts_d, dtr_d;
  always_comb begin
    if (half) begin
      rts_d = tx_st_q != SPM_TX_IDLE; // RULE16 RULE23
    end else if (hs_en) begin
      rts_d = s2n_ready; // RULE15
    end else begin
      rts_d = rts_set_q; // RULE20
    end
    dtr_d = ctrl_q[`SPM_CTRL_TRM] ? conn_up_i : dtr_set_q; // RULE18
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ser_txd_o <= 1'b1;
      ser_rts_o <= 1'b0;
      ser_dtr_o <= 1'b0;
      conn_request_o <= 1'b0;
    end else begin
      ser_txd_o <= tx_line_q ^ inv; // RULE22
      ser_rts_o <= rts_d ^ inv;
      ser_dtr_o <= dtr_d ^ inv;
      conn_request_o <= !prog && cm == 2'd3 && dsr; // RULE19
    end
  end

  // Watched lines: change under mask sets sticky bits; set beats clear
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lines_q <= 6'h00;
      note_q <= 6'h00;
      notify_req_o <= 1'b0;
      notify_port_o <= 16'h0000;
    end else begin
      lines_q <= {aux1, aux0, dsr, dtr_d, cts, rts_d};
      note_q <= (note_q & ~((wr_acc && paddr_i == `SPM_NOTIFY_OFS) ? pwdata_i[5:0] : 6'h00))
              | ((lines_q ^ {aux1, aux0, dsr, dtr_d, cts, rts_d})
                 & ctrl_q[`SPM_CTRL_NB_LO +: 6]); // RULE21
      notify_req_o <= |note_q;
      notify_port_o <= nport_q;
    end
  end

  // Read mux and decode
  always_comb begin
    rd_d = 32'h0000_0000;
    map_d = 1'b1;
    case (paddr_i)
      `SPM_CTRL_OFS: rd_d = {10'h000, ctrl_q};
      `SPM_RATE_OFS: rd_d = {16'h0000, div_q};
      `SPM_TXDATA_OFS: rd_d = {28'h000_0000, n2s_lvl};
      `SPM_RXDATA_OFS: rd_d = {22'h00_0000, s2n_valid, s2n_data};
      `SPM_PINS_OFS: rd_d = {26'h000_0000, dtr_d, rts_d, aux1, aux0, dsr, cts}; // RULE20
      `SPM_STATUS_OFS: rd_d = {25'h000_0000, esc_q, !s2n_valid, !n2s_ready,
                                |note_q, conn_up_i, half, port_open};
      `SPM_NOTIFY_OFS: rd_d = {26'h000_0000, note_q};
      `SPM_NPORT_OFS: rd_d = {16'h0000, nport_q};
      default: map_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !map_d;
      if (psel_i && penable_i && !pready_o) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_d;
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence conn_drop_s;
    conn_q && !conn_up_i;
  endsequence
  sequence bufs_empty_s;
    n2s_lvl == 4'h0 && s2n_lvl == 4'h0;
  endsequence

  prog_open_a: assert property (prog |-> port_open) // RULE4
    else $error("port closed in programming mode");
  dhcp_closed_a: assert property (!prog && ctrl_q[`SPM_CTRL_DHCP] && !ip_obtained_i // RULE5
    |-> !port_open) else $error("port open before address obtained");
  server_open_a: assert property (!prog && (!ctrl_q[`SPM_CTRL_DHCP] || ip_obtained_i) // RULE6
    && rm == SPM_RM_SERVER |-> port_open == conn_up_i) else $error("server open mismatch");
  client_open_a: assert property (!prog && (!ctrl_q[`SPM_CTRL_DHCP] || ip_obtained_i) // RULE7
    && rm != SPM_RM_SERVER && cm < 2'd2 |-> port_open) else $error("client port not open");
  cmd_open_a: assert property (!prog && (!ctrl_q[`SPM_CTRL_DHCP] || ip_obtained_i) // RULE8
    && rm != SPM_RM_SERVER && cm >= 2'd2 |-> port_open == conn_up_i)
    else $error("command trigger open mismatch");
  buf_flush_a: assert property (conn_drop_s |=> bufs_empty_s) // RULE11
    else $error("buffers not flushed on close");
  // The transmitter may pop in the same cycle, so the level may only fall
  prog_drop_a: assert property (prog && wr_acc && paddr_i == `SPM_TXDATA_OFS // RULE2
    |=> n2s_lvl <= $past(n2s_lvl)) else $error("network data kept in programming");
  rate_floor_a: assert property (div_q >= 16'(`SPM_MIN_DIV)) // RULE12
    else $error("bit period below top rate");
  dtr_conn_a: assert property (ctrl_q[`SPM_CTRL_TRM] && $stable(ctrl_q) // RULE18
    |=> ser_dtr_o == ($past(conn_up_i) ^ $past(inv)))
    else $error("dtr not showing connection");
  half_dir_a: assert property (half && $stable(ctrl_q) && tx_st_q == SPM_TX_SHIFT // RULE16
    |=> ser_rts_o == !$past(inv)) else $error("direction line low while sending");
  // A host read or a flush may change the level on their own
  closed_drop_a: assert property (rx_done_q && !port_open && !conn_fall // RULE3
    && !(rd_acc && paddr_i == `SPM_RXDATA_OFS) |=> $stable(s2n_lvl))
    else $error("closed port recorded a byte");
endmodule
`default_nettype wire

// file: bench/spm_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module spm_dev_model #(
  parameter int PER = 348
) (
  input wire logic clk_i, // Bench clock
  input wire logic txd_i, // Line from the port
  input wire logic rts_i, // Direction line from the port
  input wire logic half_i, // Half duplex in use
  output logic rxd_o // Line into the port
);
  logic [7:0] rxq[$];
  logic [7:0] b;
  // Receiver samples mid-bit; with 7-bit frames the top bit catches the stop bit
  initial begin
    forever begin
      @(posedge clk_i);
      if (txd_i === 1'b0) begin
        repeat (PER / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
          repeat (PER) @(posedge clk_i);
          b[i] = txd_i;
        end
        rxq.push_back(b);
        repeat (PER) @(posedge clk_i);
      end
    end
  end
  initial rxd_o = 1'b1;
  // One 8N1 frame, holding off while the port owns a shared line
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int n = 0; n < 5000 && half_i && rts_i; n++) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (PER) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// file: bench/serial_port_mode_and_routing_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "spm_map.svh"
module serial_port_mode_and_routing_control_tb;
  import spm_pkg::*;
  logic clk, rst, psel, pen, pwr, ip, conn, cts, dsr, a0, a1, er, hd, eo;
  logic [7:0] pa, b;
  logic [31:0] pwd, rd, prd;
  logic prdy, perr, creq, nreq, txd, rts, dtr, rxd;
  logic [15:0] nport, r16;
  int num_errors, check_count;
  spm_serial_port dut_u (.ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .ip_obtained_i(ip), .conn_up_i(conn), .conn_request_o(creq),
    .notify_req_o(nreq), .notify_port_o(nport), .ser_rxd_i(rxd), .ser_cts_i(cts),
    .ser_dsr_i(dsr), .aux_line_zero_i(a0), .aux_line_one_i(a1), .ser_txd_o(txd),
    .ser_rts_o(rts), .ser_dtr_o(dtr));
  spm_dev_model #(.PER(348)) dev_u (.clk_i(clk), .txd_i(txd), .rts_i(rts), .half_i(hd),
    .rxd_o(rxd));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // APB transfer; request held until pready is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    tmo(n, 20);
  endtask
  task automatic getb(input logic [7:0] e);
    int n;
    for (n = 0; n < 8000 && dev_u.rxq.size() == 0; n++) @(posedge clk);
    tmo(n, 8000);
    chk("txd_byte", {24'h0, dev_u.rxq.pop_front()}, {24'h0, e});
  endtask
  // Reference for the open state of the port
  function automatic logic exp_open(int p, int dy, int rm, int cm, int c);
    if (p != 0) return 1'b1;
    if (dy != 0) return 1'b0;
    if (rm == 0) return c[0];
    return (cm < 2) ? 1'b1 : c[0];
  endfunction
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    close_out();
  end
  // Main sequence
  initial begin
    {clk, psel, pen, pwr, conn, cts, dsr, a0, a1, hd} = '0;
    rst = 1'b1;
    ip = 1'b1;
    pa = 8'h00;
    pwd = 32'h0000_0000;
    num_errors = 0;
    check_count = 0;
    void'($urandom(6668));
    wt(6);
    rst <= 1'b0;
    bus(0, `SPM_CTRL_OFS, 0);
    chk("ctrl_reset", rd, 32'h0000_0800);
    bus(0, 8'h20, 0);
    chk("unmapped_err", {31'h0, er}, 32'h0000_0001);
    bus(1, `SPM_RATE_OFS, 32'h0000_0064);
    bus(0, `SPM_RATE_OFS, 0);
    chk("rate_clamp", rd, `SPM_MIN_DIV);
    for (int m = 0; m < 3; m++) for (int rm = 0; rm < 3; rm++)
      for (int cm = 0; cm < 4; cm++) for (int c = 0; c < 2; c++) begin
        conn <= c[0];
        ip <= (m != 1);
        bus(1, `SPM_CTRL_OFS, 32'h0800 | 32'(m == 2) | 32'((m == 1) << 1) | (rm << 2) | (cm << 4));
        wt(3);
        bus(0, `SPM_STATUS_OFS, 0);
        eo = exp_open(m == 2, m == 1, rm, cm, c);
        chk("open", {31'h0, rd[0]}, {31'h0, eo});
      end
    ip <= 1'b1;
    conn <= 1'b1;
    bus(1, `SPM_CTRL_OFS, 32'h0000_0800);
    b = 8'($urandom);
    bus(1, `SPM_TXDATA_OFS, {24'h0, b});
    getb(b);
    bus(1, `SPM_CTRL_OFS, 32'h0000_0000);
    bus(1, `SPM_TXDATA_OFS, {24'h0, b});
    getb({1'b1, b[6:0]});
    bus(1, `SPM_CTRL_OFS, 32'h0000_0800);
    b = 8'($urandom);
    dev_u.send(b);
    wt(10);
    bus(0, `SPM_RXDATA_OFS, 0);
    chk("rx_word", {22'h0, rd[9:0]}, {22'h0, 2'b10, b});
    bus(1, `SPM_CTRL_OFS, 32'h0000_0801);
    dev_u.send(b);
    wt(10);
    bus(0, `SPM_RXDATA_OFS, 0);
    chk("cmd_word", {22'h0, rd[9:0]}, {22'h0, 2'b11, b});
    bus(1, `SPM_TXDATA_OFS, {24'h0, b});
    bus(0, `SPM_TXDATA_OFS, 0);
    chk("prog_drop", {28'h0, rd[3:0]}, 32'h0000_0000);
    conn <= 1'b0;
    bus(1, `SPM_CTRL_OFS, 32'h0000_0C00);
    dev_u.send(8'h1B);
    wt(10);
    bus(0, `SPM_STATUS_OFS, 0);
    chk("escape", {31'h0, rd[6]}, 32'h0000_0001);
    bus(0, `SPM_RXDATA_OFS, 0);
    chk("closed_rx", {31'h0, rd[9]}, 32'h0000_0000);
    // A byte leaked in programming mode would have reached the device by now
    chk("prog_no_tx", dev_u.rxq.size(), 32'h0000_0000);
    // Back-to-back pushes leave bytes queued behind the frame in flight
    conn <= 1'b1;
    bus(1, `SPM_CTRL_OFS, 32'h0000_0800);
    for (int i = 0; i < 3; i++) bus(1, `SPM_TXDATA_OFS, 32'h0000_0055);
    conn <= 1'b0;
    wt(5);
    bus(0, `SPM_TXDATA_OFS, 0);
    chk("flush", {28'h0, rd[3:0]}, 32'h0000_0000);
    wt(4000);
    dev_u.rxq.delete();
    bus(1, `SPM_CTRL_OFS, 32'h0000_0A00);
    conn <= 1'b1;
    wt(4);
    chk("dtr_conn", {31'h0, dtr}, 32'h0000_0001);
    conn <= 1'b0;
    wt(4);
    chk("dtr_idle", {31'h0, dtr}, 32'h0000_0000);
    bus(1, `SPM_CTRL_OFS, 32'h0000_0800);
    bus(1, `SPM_PINS_OFS, 32'h0000_0002);
    wt(2);
    chk("dtr_set", {31'h0, dtr}, 32'h0000_0001);
    dsr <= 1'b1;
    a1 <= 1'b1;
    wt(6);
    bus(0, `SPM_PINS_OFS, 0);
    chk("pin_get", {29'h0, rd[3:1]}, 32'h0000_0005);
    r16 = 16'($urandom);
    bus(1, `SPM_CTRL_OFS, 32'h0008_0800);
    bus(1, `SPM_NPORT_OFS, {16'h0, r16});
    bus(1, `SPM_NOTIFY_OFS, 32'h0000_003F);
    chk("nport", {16'h0, nport}, {16'h0, r16});
    dsr <= 1'b0;
    wt(8);
    chk("notify_req", {31'h0, nreq}, 32'h0000_0001);
    bus(0, `SPM_NOTIFY_OFS, 0);
    chk("notify_bits", {26'h0, rd[5:0]}, 32'h0000_0008);
    bus(1, `SPM_CTRL_OFS, 32'h0000_0830);
    dsr <= 1'b1;
    wt(6);
    chk("conn_req_on", {31'h0, creq}, 32'h0000_0001);
    dsr <= 1'b0;
    wt(6);
    chk("conn_req_off", {31'h0, creq}, 32'h0000_0000);
    // Half duplex: direction line marks our frame, the device waits for it to end
    hd <= 1'b1;
    conn <= 1'b1;
    bus(1, `SPM_CTRL_OFS, 32'h0000_0880);
    b = 8'($urandom);
    bus(1, `SPM_TXDATA_OFS, {24'h0, b});
    wt(4);
    chk("rts_dir", {31'h0, rts}, 32'h0000_0001);
    dev_u.send(~b);
    chk("rts_idle", {31'h0, rts}, 32'h0000_0000);
    getb(b);
    wt(10);
    bus(0, `SPM_RXDATA_OFS, 0);
    chk("half_rx", {22'h0, rd[9:0]}, {22'h0, 2'b10, ~b});
    bus(1, `SPM_CTRL_OFS, 32'h0000_8800);
    wt(3);
    chk("txd_inverted", {31'h0, txd}, 32'h0000_0000);
    close_out();
  end
endmodule
`default_nettype wire
